// ---- sim/cdc_top_assertions.sv ----
// Read port checks of the debug counters
`timescale 1ns/1ps
`default_nettype none
module cdc_top_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire cdc_pkg::cdc_evt_t evt,
  input wire cdc_pkg::cdc_rd_t req,
  input wire logic [7:0] rdata,
  input wire logic hit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_hi;
    req.rd && req.addr == 8'h90 && !evt.frame_done;
  endsequence
  sequence s_err_hi;
    req.rd && req.addr == 8'h92 && !evt.frame_err;
  endsequence
  sequence s_line_hi;
    req.rd && req.addr == 8'h94 && !evt.line_done;
  endsequence
  sequence s_lo;
    req.rd && req.addr == 8'h91;
  endsequence
  property p_clr_err; s_err_hi ##1 s_err_hi |=> rdata == 8'h00; endproperty
  property p_clr_line; s_line_hi ##1 s_line_hi |=> rdata == 8'h00; endproperty
  property p_lo_hold; s_lo ##1 s_lo |=> $stable(rdata); endproperty
  property p_idle; !req.rd |=> !hit && rdata == 8'h00; endproperty
  property p_map; req.rd && req.addr inside {[8'h90:8'h95]} |=> hit; endproperty
  property p_miss; req.rd && !(req.addr inside {[8'h90:8'h95]}) |=> !hit && rdata == 8'h00;
  endproperty
  property p_clr; s_hi ##1 s_hi |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  a_map: assert property (p_map) else $error("no hit");
  a_miss: assert property (p_miss) else $error("unmapped answered");
  a_clr: assert property (p_clr) else $error("not cleared");
  a_clr_err: assert property (p_clr_err) else $error("errored count not cleared");
  a_clr_line: assert property (p_clr_line) else $error("line count not cleared");
  a_lo_hold: assert property (p_lo_hold) else $error("low register not held");
endmodule // cdc_top_assertions
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench of the debug counters
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cdc_pkg::*;
  logic mclk, reset, hit;
  cdc_evt_t evt;
  cdc_rd_t req;
  logic [7:0] rdata;
  int err_total, compares;
  cdc_top cdc_top_i (.mclk(mclk), .reset(reset), .evt(evt), .req(req), .rdata(rdata), .hit(hit));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task check(string name, logic [8:0] seen, logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s exp %h got %h", name, exp, seen);
    end
  endtask
  // Read held n cycles; the last answer stands until the next edge
  task rd(logic [7:0] a, int n, logic [7:0] e, logic h);
    @(negedge mclk);
    req = '{1'b1, a};
    repeat (n) @(negedge mclk);
    check($sformatf("read_%h", a), {hit, rdata}, {h, e});
    req.rd = 1'b0;
  endtask
  task ev(cdc_evt_t e, int n);
    @(negedge mclk);
    evt = e;
    repeat (n) @(negedge mclk);
    evt = '0;
  endtask
  task test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    evt = '0;
    req = '0;
    err_total = 0;
    compares = 0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    for (int a = 'h90; a < 'h96; a++) rd(a[7:0], 1, 8'h00, 1'b1);
    ev(3'b110, 'h105);
    ev(3'b100, 'hFE);
    rd(8'h90, 1, 8'h02, 1'b1);
    ev(3'b100, 4);
    rd(8'h91, 1, 8'h03, 1'b1);
    rd(8'h90, 2, 8'h00, 1'b1);
    rd(8'h91, 2, 8'h00, 1'b1);
    rd(8'h92, 1, 8'h01, 1'b1);
    rd(8'h93, 1, 8'h05, 1'b1);
    rd(8'h92, 2, 8'h00, 1'b1);
    ev(3'b001, 'h10002);
    rd(8'h94, 1, 8'h00, 1'b1);
    rd(8'h95, 1, 8'h02, 1'b1);
    rd(8'h94, 2, 8'h00, 1'b1);
    rd(8'h96, 1, 8'h00, 1'b0);
    evt = 3'b100;
    rd(8'h90, 1, 8'h00, 1'b1);
    evt = '0;
    rd(8'h90, 1, 8'h00, 1'b1);
    rd(8'h91, 1, 8'h01, 1'b1);
    ev(3'b111, 3);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    rd(8'h95, 1, 8'h00, 1'b1);
    rd(8'h94, 1, 8'h00, 1'b1);
    rd(8'h95, 1, 8'h00, 1'b1);
    rd(8'h91, 1, 8'h00, 1'b1);
    rd(8'h92, 1, 8'h00, 1'b1);
    rd(8'h93, 1, 8'h00, 1'b1);
    test_done();
  end
endmodule // testbench
bind cdc_top cdc_top_assertions chk_i (.mclk(mclk), .reset(reset), .evt(evt), .req(req),
  .rdata(rdata), .hit(hit));
`default_nettype wire

// ---- src/cdc_counter.sv ----
// One read-clear 16-bit counter with low-byte snapshot
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"
module cdc_counter #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic inc,
  input wire logic rd_high,
  output logic [7:0] high_byte,
  output logic [7:0] low_snap
);
  import cdc_pkg::*;

  // Byte split and snapshot assume a 16-bit count
  if (WIDTH != 16) begin : g_bad_width
    $error("cdc_counter supports 16-bit counters only");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic [7:0] snap;
  } cdc_cnt_state_t;

  cdc_cnt_state_t st_ff;
  cdc_cnt_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (rd_high) begin
      // Clear on read; an event in the same cycle starts the new count
      nxt_st.snap = st_ff.cnt[7:0];
      nxt_st.cnt = inc ? WIDTH'(1) : `CDC_CNT_RESET;
    end else if (inc) begin
      nxt_st.cnt = st_ff.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '{cnt: `CDC_CNT_RESET, snap: `CDC_SNAP_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign high_byte = st_ff.cnt[`CDC_FLD_HIGH_MSB:`CDC_FLD_HIGH_LSB];
  assign low_snap = st_ff.snap;
endmodule // cdc_counter
`default_nettype wire

// ---- src/cdc_defs.svh ----
// Offsets, field positions and reset values of the output debug counters
// Function
// - Count output frames in 16 bits; high read returns MSBs, snapshots LSBs, clears.
// - Frame-total low read returns LSBs snapshotted by the last high read.
// - Count errored output frames in 16 bits; high read returns MSBs, snapshots, clears.
// - Errored-frame low read returns LSBs snapshotted by the last high read.
// - Count output lines in 16 bits; high read returns MSBs, snapshots LSBs, clears.
// - Line-total low returns snapshotted LSBs; software reads high first.
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH
`define CDC_ADDR_FRAME_TOTAL_HIGH 8'h90
`define CDC_ADDR_FRAME_TOTAL_LOW 8'h91
`define CDC_ADDR_ERRORED_FRAME_HIGH 8'h92
`define CDC_ADDR_ERRORED_FRAME_LOW 8'h93
`define CDC_ADDR_LINE_TOTAL_HIGH 8'h94
`define CDC_ADDR_LINE_TOTAL_LOW 8'h95
`define CDC_CNT_RESET 16'h0000
`define CDC_SNAP_RESET 8'h00
`define CDC_FLD_HIGH_MSB 15
`define CDC_FLD_HIGH_LSB 8
`endif

// ---- src/cdc_pkg.sv ----
// Types shared by the output debug counter block
package cdc_pkg;
  typedef struct packed {
    logic frame_done;
    logic frame_err;
    logic line_done;
  } cdc_evt_t;
  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } cdc_rd_t;
endpackage

// ---- src/cdc_top.sv ----
// Register bank of frame, errored-frame and line counters for the output port
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"
module cdc_top (
  input wire logic mclk,
  input wire logic reset,
  input wire cdc_pkg::cdc_evt_t evt,
  input wire cdc_pkg::cdc_rd_t req,
  output logic [7:0] rdata,
  output logic hit
);
  import cdc_pkg::*;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  // Frame total, errored frames, line total
  localparam int NUM_CNT = 3;
  localparam int CNT_W = 16;

  // Slot code of the counter a register belongs to
  localparam int SLOT_W = 2;

  // Code NUM_CNT means no counter addressed
  localparam logic [SLOT_W-1:0] SLOT_NONE = SLOT_W'(NUM_CNT);
  localparam logic [SLOT_W-1:0] SLOT_FRAME = SLOT_W'(0);
  localparam logic [SLOT_W-1:0] SLOT_ERRORED = SLOT_W'(1);
  localparam logic [SLOT_W-1:0] SLOT_LINE = SLOT_W'(2);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Slot code must leave room for the none code
  if (NUM_CNT >= (1 << SLOT_W)) begin : g_bad_slot_w
    $error("slot code too narrow for the counter count");
  end

  // High byte field must be the top byte of the count
  if (`CDC_FLD_HIGH_MSB != CNT_W - 1 || `CDC_FLD_HIGH_LSB != 8) begin : g_bad_field
    $error("high byte field does not match the counter width");
  end

  // Low registers sit one above their high registers
  if (`CDC_ADDR_FRAME_TOTAL_LOW != `CDC_ADDR_FRAME_TOTAL_HIGH + 1) begin : g_bad_frame_map
    $error("frame-total low register must follow its high register");
  end

  if (`CDC_ADDR_ERRORED_FRAME_LOW != `CDC_ADDR_ERRORED_FRAME_HIGH + 1) begin : g_bad_err_map
    $error("errored-frame low register must follow its high register");
  end

  if (`CDC_ADDR_LINE_TOTAL_LOW != `CDC_ADDR_LINE_TOTAL_HIGH + 1) begin : g_bad_line_map
    $error("line-total low register must follow its high register");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Counter whose high register sits at addr; reading it clears that counter
  function automatic logic [SLOT_W-1:0] high_slot(input logic [7:0] addr);
    logic [SLOT_W-1:0] slot;
    slot = SLOT_NONE;
    case (addr)
      `CDC_ADDR_FRAME_TOTAL_HIGH: begin
        slot = SLOT_FRAME;
      end
      `CDC_ADDR_ERRORED_FRAME_HIGH: begin
        slot = SLOT_ERRORED;
      end
      `CDC_ADDR_LINE_TOTAL_HIGH: begin
        slot = SLOT_LINE;
      end
      default: begin
        slot = SLOT_NONE;
      end
    endcase
    return slot;
  endfunction

  // Counter whose snapshot register sits at addr; reading it has no side effect
  function automatic logic [SLOT_W-1:0] low_slot(input logic [7:0] addr);
    logic [SLOT_W-1:0] slot;
    slot = SLOT_NONE;
    case (addr)
      `CDC_ADDR_FRAME_TOTAL_LOW: begin
        slot = SLOT_FRAME;
      end
      `CDC_ADDR_ERRORED_FRAME_LOW: begin
        slot = SLOT_ERRORED;
      end
      `CDC_ADDR_LINE_TOTAL_LOW: begin
        slot = SLOT_LINE;
      end
      default: begin
        slot = SLOT_NONE;
      end
    endcase
    return slot;
  endfunction

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic [SLOT_W-1:0] rd_high_slot;
  logic [SLOT_W-1:0] rd_low_slot;

  assign rd_high_slot = req.rd ? high_slot(req.addr) : SLOT_NONE;
  assign rd_low_slot = req.rd ? low_slot(req.addr) : SLOT_NONE;

  // ----------------------------------------
  // Event routing
  // ----------------------------------------
  // Errored frames count on their own pulse, not on frame_done
  logic [NUM_CNT-1:0] inc_v;

  assign inc_v[0] = evt.frame_done;
  assign inc_v[1] = evt.frame_err;
  assign inc_v[2] = evt.line_done;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [7:0] hi_byte [NUM_CNT];
  logic [7:0] lo_byte [NUM_CNT];
  logic [NUM_CNT-1:0] rdh_v;

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    assign rdh_v[i] = (rd_high_slot == SLOT_W'(i));

    cdc_counter #(
      .WIDTH(CNT_W)
    ) u_cnt (
      .mclk(mclk),
      .reset(reset),
      .inc(inc_v[i]),
      .rd_high(rdh_v[i]),
      .high_byte(hi_byte[i]),
      .low_snap(lo_byte[i])
    );
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
  } cdc_rd_state_t;

  cdc_rd_state_t st_ff;
  cdc_rd_state_t nxt_st;

  // Unmapped reads answer zero with no hit
  always_comb begin
    nxt_st.rdata = 8'h00;
    nxt_st.hit = 1'b0;
    for (int k = 0; k < NUM_CNT; k++) begin
      if (rd_high_slot == SLOT_W'(k)) begin
        nxt_st.hit = 1'b1;
        nxt_st.rdata = hi_byte[k];
      end
      if (rd_low_slot == SLOT_W'(k)) begin
        nxt_st.hit = 1'b1;
        nxt_st.rdata = lo_byte[k];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '{rdata: 8'h00, hit: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Answer stands for one cycle after the read
  assign rdata = st_ff.rdata;
  assign hit = st_ff.hit;
endmodule // cdc_top
`default_nettype wire
